// ===== src/sos_pkg.sv
// ----------------------------------------------------------------
// status output selector: shared constants
// ----------------------------------------------------------------
package sos_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int SOS_NUM_OUT = 4;
    localparam int SOS_SPD_W = 16;
    localparam int SOS_CUR_W = 16;
    localparam int SOS_CAP_W = 8;
    localparam int SOS_ERR_W = 16;
    localparam int SOS_SEL_W = 5;

    // thermal accumulator value that means full capacity, in percent
    localparam logic [7:0] SOS_CAP_FULL = 8'h64;

    // reset value of the physical outputs (inactive)
    localparam logic [3:0] SOS_OUT_RST = 4'h0;

    // ------------------------------------------------------------
    // condition selection codes
    // ------------------------------------------------------------
    localparam logic [4:0] SOS_SEL_OFF = 5'h00;
    localparam logic [4:0] SOS_SEL_ZERO_SPD = 5'h01;
    localparam logic [4:0] SOS_SEL_AT_SPD = 5'h02;
    localparam logic [4:0] SOS_SEL_SET_SPD = 5'h03;
    localparam logic [4:0] SOS_SEL_OVERLOAD = 5'h04;
    localparam logic [4:0] SOS_SEL_UNDERLOAD = 5'h05;
    localparam logic [4:0] SOS_SEL_THERMAL = 5'h06;
    localparam logic [4:0] SOS_SEL_KEYPAD = 5'h07;
    localparam logic [4:0] SOS_SEL_BRAKE = 5'h08;
    localparam logic [4:0] SOS_SEL_FOLDBACK = 5'h09;
    localparam logic [4:0] SOS_SEL_FAULT = 5'h0A;
    localparam logic [4:0] SOS_SEL_ALARM = 5'h0B;
    localparam logic [4:0] SOS_SEL_CMD_FWD = 5'h0C;
    localparam logic [4:0] SOS_SEL_CMD_REV = 5'h0D;
    localparam logic [4:0] SOS_SEL_MOT_FWD = 5'h0E;
    localparam logic [4:0] SOS_SEL_MOT_REV = 5'h0F;
    localparam logic [4:0] SOS_SEL_PROC_ERR = 5'h10;
    localparam logic [4:0] SOS_SEL_NETWORK = 5'h11;
    localparam logic [4:0] SOS_SEL_AT_POS = 5'h12;
    localparam logic [4:0] SOS_SEL_IN_MOTION = 5'h13;
    localparam logic [4:0] SOS_SEL_LADDER = 5'h14;
    localparam logic [4:0] SOS_SEL_CALENDAR = 5'h15;
    // highest code in use; anything above reads as inactive
    localparam logic [4:0] SOS_SEL_LAST = 5'h15;

    // ------------------------------------------------------------
    // state of the selector
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] outBits;
    } sos_state_s;

endpackage : sos_pkg

// ===== src/sos_status_output_selector.sv
// Operation
// [RULE1] four outputs, each reports one condition
// [RULE2] zero speed: speed below threshold
// [RULE3] at speed: reference minus demand within band
// [RULE4] set speed: output speed at or above point
// [RULE5] overload: current above overload set point
// [RULE6] underload: current below underload set point
// [RULE7] thermal: remaining capacity below full
// [RULE8] keypad: drive under local keypad authority
// [RULE9] brake: braking transistor switched on
// [RULE10] foldback: current foldback limiting active
// [RULE11] fault: tripping fault present
// [RULE12] alarm: non-tripping alarm present
// [RULE13] command forward/reverse follow run command
// [RULE14] motor forward/reverse follow measured rotation
// [RULE15] process error: magnitude above tolerance
// [RULE16] network: follows remote master written value
// [RULE17] at position: load reached target
// [RULE18] in motion: load moving toward target
// [RULE19] ladder and calendar follow function command
// [RULE20] update every cycle, inactive in reset
// [RULE21] binary select index, unused codes inactive
`timescale 1ns/1ps
`default_nettype none

module sos_status_output_selector
    import sos_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    // per-output condition select
    input wire logic [3:0][4:0] outSel,
    // speed signals, signed rpm units
    input wire logic signed [15:0] motorSpeed,
    input wire logic signed [15:0] speedRef,
    input wire logic signed [15:0] speedDemand,
    input wire logic signed [15:0] outputSpeed,
    input wire logic [15:0] zero_speed_threshold,
    input wire logic [15:0] at_speed_band,
    input wire logic [15:0] set_speed_point,
    // current signals
    input wire logic [15:0] motorCurrent,
    input wire logic [15:0] overloadSetPoint,
    input wire logic [15:0] underloadSetPoint,
    input wire logic [7:0] overloadLeft,
    // drive state flags
    input wire logic keypadControl,
    input wire logic brakeOn,
    input wire logic foldbackActive,
    input wire logic faultPresent,
    input wire logic alarmPresent,
    input wire logic runCmdFwd,
    input wire logic runCmdRev,
    input wire logic motorDirFwd,
    input wire logic motorDirRev,
    // process loop
    input wire logic signed [15:0] processError,
    input wire logic [15:0] process_error_tolerance,
    // positioning
    input wire logic atPosition,
    input wire logic inMotion,
    // externally commanded outputs, one bit per output
    input wire logic [3:0] networkCmd,
    input wire logic [3:0] ladder_logic_mode_cmd,
    input wire logic [3:0] calendarCmd,
    // outputs 0,1 opto, 2,3 relay
    output logic [3:0] digOut
);

    // ------------------------------------------------------------
    // magnitude helper
    // ------------------------------------------------------------
    // one extra bit so the most negative value does not wrap
    function automatic logic [16:0] absVal(input logic signed [16:0] v);
        logic [16:0] r;
        r = v[16] ? 17'(-v) : 17'(v);
        return r;
    endfunction : absVal

    logic [16:0] speedMag;
    logic [16:0] outSpeedMag;
    logic [16:0] speedDiffMag;
    logic [16:0] procErrMag;

    // magnitudes of signed inputs
    always_comb begin
        speedMag = absVal(17'(motorSpeed));
        outSpeedMag = absVal(17'(outputSpeed));
        // at-speed compares ramp input against ramp output
        speedDiffMag = absVal(17'(speedRef) - 17'(speedDemand));
        procErrMag = absVal(17'(processError));
    end

    // ------------------------------------------------------------
    // shared comparisons
    // ------------------------------------------------------------
    logic condZeroSpd;
    logic condAtSpd;
    logic condSetSpd;
    logic condOverload;
    logic condUnderload;
    logic condThermal;
    logic condProcErr;

    // comparisons are shared by all four outputs
    always_comb begin
        // [RULE2] zero speed compare
        condZeroSpd = speedMag < {1'b0, zero_speed_threshold};
        // [RULE3] at speed band
        condAtSpd = speedDiffMag < {1'b0, at_speed_band};
        // [RULE4] set speed point
        condSetSpd = outSpeedMag >= {1'b0, set_speed_point};
        // [RULE5] overload compare
        condOverload = motorCurrent > overloadSetPoint;
        // [RULE6] underload compare
        condUnderload = motorCurrent < underloadSetPoint;
        // [RULE7] thermal capacity below full
        condThermal = overloadLeft < SOS_CAP_FULL;
        // [RULE15] process error tolerance
        condProcErr = procErrMag > {1'b0, process_error_tolerance};
    end

    // ------------------------------------------------------------
    // per-output selection
    // ------------------------------------------------------------
    logic [3:0] selBits;

    // [RULE1] one independent selector per output
    for (genvar i = 0; i < SOS_NUM_OUT; i++) begin : gSel
        always_comb begin
            // [RULE21] unused codes fall to inactive
            selBits[i] = 1'b0;
            case (outSel[i])
                SOS_SEL_ZERO_SPD: selBits[i] = condZeroSpd;
                SOS_SEL_AT_SPD: selBits[i] = condAtSpd;
                SOS_SEL_SET_SPD: selBits[i] = condSetSpd;
                SOS_SEL_OVERLOAD: selBits[i] = condOverload;
                SOS_SEL_UNDERLOAD: selBits[i] = condUnderload;
                SOS_SEL_THERMAL: selBits[i] = condThermal;
                // [RULE8] keypad authority
                SOS_SEL_KEYPAD: selBits[i] = keypadControl;
                // [RULE9] braking transistor
                SOS_SEL_BRAKE: selBits[i] = brakeOn;
                // [RULE10] foldback limiting
                SOS_SEL_FOLDBACK: selBits[i] = foldbackActive;
                // [RULE11] tripping fault
                SOS_SEL_FAULT: selBits[i] = faultPresent;
                // [RULE12] non-tripping alarm
                SOS_SEL_ALARM: selBits[i] = alarmPresent;
                // [RULE13] run command state
                SOS_SEL_CMD_FWD: selBits[i] = runCmdFwd;
                SOS_SEL_CMD_REV: selBits[i] = runCmdRev;
                // [RULE14] measured rotation
                SOS_SEL_MOT_FWD: selBits[i] = motorDirFwd;
                SOS_SEL_MOT_REV: selBits[i] = motorDirRev;
                SOS_SEL_PROC_ERR: selBits[i] = condProcErr;
                // [RULE16] remote master value
                SOS_SEL_NETWORK: selBits[i] = networkCmd[i];
                // [RULE17] target reached
                SOS_SEL_AT_POS: selBits[i] = atPosition;
                // [RULE18] moving to target
                SOS_SEL_IN_MOTION: selBits[i] = inMotion;
                // [RULE19] function command pass-through
                SOS_SEL_LADDER: selBits[i] = ladder_logic_mode_cmd[i];
                SOS_SEL_CALENDAR: selBits[i] = calendarCmd[i];
                default: selBits[i] = 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    sos_state_s state_reg;
    sos_state_s state_next;

    // next state: fresh sample every cycle, no hysteresis
    always_comb begin
        state_next = state_reg;
        state_next.outBits = selBits;
    end

    // [RULE20] registered once per cycle, cleared in reset
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '{outBits: SOS_OUT_RST};
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from the flops, glitch free for relays
    assign digOut = state_reg.outBits;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // a limitation: outputs lag the inputs by one clock

    property p_zeroSpd;
        @(posedge ref_clk) disable iff (!rst_n)
        (outSel[0] == SOS_SEL_ZERO_SPD) |=> (digOut[0] == $past(condZeroSpd));
    endproperty
    a_zeroSpd: assert property (p_zeroSpd) // [RULE2]
        else $error("zero speed output wrong");

    property p_zeroSpdVal;
        @(posedge ref_clk) disable iff (!rst_n)
        (outSel[1] == SOS_SEL_ZERO_SPD && motorSpeed == 16'sh0000
            && zero_speed_threshold != 16'h0000) |=> digOut[1];
    endproperty
    a_zeroSpdVal: assert property (p_zeroSpdVal) // [RULE2]
        else $error("zero speed not flagged at standstill");

    property p_atSpd;
        @(posedge ref_clk) disable iff (!rst_n)
        (outSel[2] == SOS_SEL_AT_SPD && speedRef == speedDemand
            && at_speed_band != 16'h0000) |=> digOut[2];
    endproperty
    a_atSpd: assert property (p_atSpd) // [RULE3]
        else $error("at speed not flagged with zero difference");

    property p_setSpd;
        @(posedge ref_clk) disable iff (!rst_n)
        (outSel[3] == SOS_SEL_SET_SPD && outputSpeed >= 16'sh0000
            && outputSpeed == $signed(set_speed_point)) |=> digOut[3];
    endproperty
    a_setSpd: assert property (p_setSpd) // [RULE4]
        else $error("set speed not flagged at the point");

    property p_overload;
        @(posedge ref_clk) disable iff (!rst_n)
        (outSel[0] == SOS_SEL_OVERLOAD && motorCurrent == overloadSetPoint)
            |=> !digOut[0];
    endproperty
    a_overload: assert property (p_overload) // [RULE5]
        else $error("overload flagged at equal current");

    property p_underload;
        @(posedge ref_clk) disable iff (!rst_n)
        (outSel[1] == SOS_SEL_UNDERLOAD) |=>
            (digOut[1] == ($past(motorCurrent) < $past(underloadSetPoint)));
    endproperty
    a_underload: assert property (p_underload) // [RULE6]
        else $error("underload output wrong");

    property p_thermal;
        @(posedge ref_clk) disable iff (!rst_n)
        (outSel[2] == SOS_SEL_THERMAL) |=>
            (digOut[2] == ($past(overloadLeft) < SOS_CAP_FULL));
    endproperty
    a_thermal: assert property (p_thermal) // [RULE7]
        else $error("thermal output wrong");

    property p_fault;
        @(posedge ref_clk) disable iff (!rst_n)
        (outSel[3] == SOS_SEL_FAULT && faultPresent)[*2] |-> digOut[3];
    endproperty
    a_fault: assert property (p_fault) // [RULE11]
        else $error("fault output not held");

    property p_network;
        @(posedge ref_clk) disable iff (!rst_n)
        (outSel[1] == SOS_SEL_NETWORK) |=> (digOut[1] == $past(networkCmd[1]));
    endproperty
    a_network: assert property (p_network) // [RULE16]
        else $error("network output does not follow master");

    property p_ladder;
        @(posedge ref_clk) disable iff (!rst_n)
        (outSel[2] == SOS_SEL_LADDER) |=>
            (digOut[2] == $past(ladder_logic_mode_cmd[2]));
    endproperty
    a_ladder: assert property (p_ladder) // [RULE19]
        else $error("ladder output does not follow command");

    property p_keypad;
        @(posedge ref_clk) disable iff (!rst_n)
        (outSel[1] == SOS_SEL_KEYPAD) |=> (digOut[1] == $past(keypadControl));
    endproperty
    a_keypad: assert property (p_keypad) // [RULE8]
        else $error("keypad output does not follow authority");

    property p_brake;
        @(posedge ref_clk) disable iff (!rst_n)
        (outSel[2] == SOS_SEL_BRAKE) |=> (digOut[2] == $past(brakeOn));
    endproperty
    a_brake: assert property (p_brake) // [RULE9]
        else $error("brake output does not follow transistor");

    property p_foldback;
        @(posedge ref_clk) disable iff (!rst_n)
        (outSel[3] == SOS_SEL_FOLDBACK) |=> (digOut[3] == $past(foldbackActive));
    endproperty
    a_foldback: assert property (p_foldback) // [RULE10]
        else $error("foldback output does not follow limiter");

    property p_alarm;
        @(posedge ref_clk) disable iff (!rst_n)
        (outSel[0] == SOS_SEL_ALARM) |=> (digOut[0] == $past(alarmPresent));
    endproperty
    a_alarm: assert property (p_alarm) // [RULE12]
        else $error("alarm output does not follow alarm");

    property p_motFwd;
        @(posedge ref_clk) disable iff (!rst_n)
        (outSel[1] == SOS_SEL_MOT_FWD) |=> (digOut[1] == $past(motorDirFwd));
    endproperty
    a_motFwd: assert property (p_motFwd) // [RULE14]
        else $error("motor forward output does not follow rotation");

    // non-negative half only, so the check needs no magnitude logic of its own
    property p_procErr;
        @(posedge ref_clk) disable iff (!rst_n)
        (outSel[2] == SOS_SEL_PROC_ERR && !processError[15]) |=>
            (digOut[2] == ($past(processError[14:0]) > $past(process_error_tolerance)));
    endproperty
    a_procErr: assert property (p_procErr) // [RULE15]
        else $error("process error output wrong");

    property p_atPos;
        @(posedge ref_clk) disable iff (!rst_n)
        (outSel[3] == SOS_SEL_AT_POS) |=> (digOut[3] == $past(atPosition));
    endproperty
    a_atPos: assert property (p_atPos) // [RULE17]
        else $error("at position output does not follow positioner");

    property p_inMotion;
        @(posedge ref_clk) disable iff (!rst_n)
        (outSel[0] == SOS_SEL_IN_MOTION) |=> (digOut[0] == $past(inMotion));
    endproperty
    a_inMotion: assert property (p_inMotion) // [RULE18]
        else $error("in motion output does not follow positioner");

    property p_calendar;
        @(posedge ref_clk) disable iff (!rst_n)
        (outSel[3] == SOS_SEL_CALENDAR) |=> (digOut[3] == $past(calendarCmd[3]));
    endproperty
    a_calendar: assert property (p_calendar) // [RULE19]
        else $error("calendar output does not follow command");

    property p_cmdDir;
        @(posedge ref_clk) disable iff (!rst_n)
        (outSel[0] == SOS_SEL_CMD_REV && $stable(outSel[0]) && $rose(runCmdRev))
            |=> $rose(digOut[0]);
    endproperty
    a_cmdDir: assert property (p_cmdDir) // [RULE13]
        else $error("command reverse edge lost");

    property p_unused;
        @(posedge ref_clk) disable iff (!rst_n)
        (outSel[3] > SOS_SEL_LAST || outSel[3] == SOS_SEL_OFF) |=> !digOut[3];
    endproperty
    a_unused: assert property (p_unused) // [RULE21]
        else $error("unused code drives output");

    property p_reset;
        @(posedge ref_clk) !rst_n |-> (digOut == SOS_OUT_RST);
    endproperty
    a_reset: assert property (p_reset) // [RULE20]
        else $error("outputs active during reset");

endmodule : sos_status_output_selector

`default_nettype wire

// ===== tb/sos_net_master.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// remote network master: owns the network-controlled bits
// ------------------------------------------------------------
module sos_net_master (
    input wire logic ref_clk,
    input wire logic rst_n,
    output logic [3:0] networkCmd
);
    logic [7:0] lfsrReg;

    // master alone writes
    // writes land on a clock edge so the selector never sees a torn value
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lfsrReg <= 8'hA5;
            networkCmd <= 4'h0;
        end else begin
            lfsrReg <= {lfsrReg[6:0], lfsrReg[7] ^ lfsrReg[5] ^ lfsrReg[4] ^ lfsrReg[3]};
            if (lfsrReg[0]) begin
                networkCmd <= lfsrReg[4:1];
            end
        end
    end
endmodule : sos_net_master

`default_nettype wire

// ===== tb/sos_status_output_selector_tb.sv
`timescale 1ns/1ps
`default_nettype none

module sos_status_output_selector_tb
    import sos_pkg::*;
;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic ref_clk = 1'b0;
    logic rst_n = 1'b1; // dropped after time zero so the flops see a real reset edge
    logic [3:0][4:0] outSel = '0;
    logic signed [15:0] motorSpeed = '0, speedRef = '0, speedDemand = '0;
    logic signed [15:0] outputSpeed = '0, processError = '0;
    logic [15:0] zeroThr = '0, atBand = '0, setPoint = '0, motorCurrent = '0;
    logic [15:0] overSet = '0, underSet = '0, errTol = '0;
    logic [7:0] overloadLeft = 8'h64;
    // keypad brake foldback fault alarm cmdF cmdR motF motR atPos inMotion
    logic [10:0] flags = '0;
    logic [3:0] networkCmd;
    logic [3:0] ladderCmd = '0;
    logic [3:0] calendarCmd = '0;
    logic [3:0] digOut;
    logic [3:0] expQ[$];
    int n_errors = 0;
    int n_checks = 0;
    int seed = 92;

    always #5 ref_clk = ~ref_clk;

    sos_net_master netMaster (.ref_clk(ref_clk), .rst_n(rst_n), .networkCmd(networkCmd));

    sos_status_output_selector DUT (
        .ref_clk(ref_clk), .rst_n(rst_n), .outSel(outSel), .motorSpeed(motorSpeed),
        .speedRef(speedRef), .speedDemand(speedDemand), .outputSpeed(outputSpeed),
        .zero_speed_threshold(zeroThr), .at_speed_band(atBand), .set_speed_point(setPoint),
        .motorCurrent(motorCurrent), .overloadSetPoint(overSet), .underloadSetPoint(underSet),
        .overloadLeft(overloadLeft), .keypadControl(flags[0]), .brakeOn(flags[1]),
        .foldbackActive(flags[2]), .faultPresent(flags[3]), .alarmPresent(flags[4]),
        .runCmdFwd(flags[5]), .runCmdRev(flags[6]), .motorDirFwd(flags[7]),
        .motorDirRev(flags[8]), .processError(processError),
        .process_error_tolerance(errTol), .atPosition(flags[9]), .inMotion(flags[10]),
        .networkCmd(networkCmd), .ladder_logic_mode_cmd(ladderCmd),
        .calendarCmd(calendarCmd), .digOut(digOut)
    );

    // ------------------------------------------------------------
    // reference model and checking
    // ------------------------------------------------------------
    function automatic int mag(input int v);
        return (v < 0) ? -v : v;
    endfunction : mag

    function automatic logic [3:0] exp_all();
        logic [3:0] e;
        for (int i = 0; i < 4; i++) begin
            case (outSel[i])
                SOS_SEL_ZERO_SPD: e[i] = mag(motorSpeed) < int'(zeroThr);
                SOS_SEL_AT_SPD: e[i] = mag(speedRef - speedDemand) < int'(atBand);
                SOS_SEL_SET_SPD: e[i] = mag(outputSpeed) >= int'(setPoint);
                SOS_SEL_OVERLOAD: e[i] = motorCurrent > overSet;
                SOS_SEL_UNDERLOAD: e[i] = motorCurrent < underSet;
                SOS_SEL_THERMAL: e[i] = overloadLeft < SOS_CAP_FULL;
                SOS_SEL_KEYPAD, SOS_SEL_BRAKE, SOS_SEL_FOLDBACK, SOS_SEL_FAULT, SOS_SEL_ALARM,
                SOS_SEL_CMD_FWD, SOS_SEL_CMD_REV, SOS_SEL_MOT_FWD, SOS_SEL_MOT_REV:
                    e[i] = flags[outSel[i] - SOS_SEL_KEYPAD];
                SOS_SEL_AT_POS: e[i] = flags[9];
                SOS_SEL_IN_MOTION: e[i] = flags[10];
                SOS_SEL_PROC_ERR: e[i] = mag(processError) > int'(errTol);
                SOS_SEL_NETWORK: e[i] = networkCmd[i];
                SOS_SEL_LADDER: e[i] = ladderCmd[i];
                SOS_SEL_CALENDAR: e[i] = calendarCmd[i];
                default: e[i] = 1'b0;
            endcase
        end
        return e;
    endfunction : exp_all

    task automatic chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    // monitor: each note is due one edge after it was queued
    always begin
        @(posedge ref_clk);
        if (expQ.size() > 0) begin
            #2;
            chk("digOut", digOut, expQ.pop_front());
        end
    end

    // ------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------
    // small value ranges so thresholds are hit exactly, not just straddled
    task automatic step(input int sel);
        @(posedge ref_clk);
        #1;
        for (int i = 0; i < 4; i++) begin
            outSel[i] = (sel < 0) ? 5'($random(seed)) : 5'(sel);
        end
        {motorSpeed, speedRef} = {16'($random(seed) % 64), 16'($random(seed) % 64)};
        {speedDemand, outputSpeed} = {16'($random(seed) % 64), 16'($random(seed) % 64)};
        {processError, motorCurrent} = {16'($random(seed) % 64), 16'($random(seed) & 63)};
        {zeroThr, atBand, setPoint} = {16'($random(seed) & 63), 16'($random(seed) & 63),
            16'($random(seed) & 63)};
        {overSet, underSet, errTol} = {16'($random(seed) & 63), 16'($random(seed) & 63),
            16'($random(seed) & 63)};
        overloadLeft = 8'(96 + ($random(seed) & 7));
        flags = 11'($random(seed));
        {ladderCmd, calendarCmd} = 8'($random(seed));
        // about one step in four sits exactly on the compare edges
        if (($random(seed) & 3) == 0) begin
            {motorSpeed, speedDemand, outputSpeed} = {16'h0000, speedRef, setPoint};
            motorCurrent = overSet;
        end
        expQ.push_back(exp_all());
    endtask : step

    task automatic reset_mid();
        repeat (2) @(posedge ref_clk);
        #1;
        outSel = {4{SOS_SEL_FAULT}};
        flags[3] = 1'b1;
        rst_n = 1'b0;
        #1;
        chk("digOut_in_reset", digOut, SOS_OUT_RST);
        repeat (3) @(posedge ref_clk);
        #1;
        chk("digOut_held_reset", digOut, SOS_OUT_RST);
        rst_n = 1'b1;
        expQ.push_back(exp_all());
    endtask : reset_mid

    initial begin
        #1;
        rst_n = 1'b0;
        repeat (10) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        for (int c = 0; c < 32; c++) begin
            repeat (8) step(c);
        end
        $display("test every_code done");
        for (int t = 0; t < 600; t++) step(-1);
        $display("test random_mix done");
        reset_mid();
        for (int t = 0; t < 200; t++) step(-1);
        $display("test mid_reset done");
        repeat (3) @(posedge ref_clk);
        final_report();
    end

    // watchdog: bounded run length
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        $display("Error watchdog expected finish seen timeout");
        final_report();
    end
endmodule : sos_status_output_selector_tb

`default_nettype wire
